// [hfcl_pkg.sv]
package hfcl_pkg;
  // Byte codes of the ASCII exchange
  localparam logic [7:0] CH_REQ = 8'h25;
  localparam logic [7:0] CH_RSP = 8'h23;
  localparam logic [7:0] CH_CMD = 8'h41;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  // Node addresses
  localparam logic [4:0] ADDR_DEFAULT = 5'h06;
  localparam logic [4:0] ADDR_HOST = 5'h02;
  localparam logic [4:0] ADDR_MIN = 5'h07;
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  // Relative current scale, five decimal digits
  localparam int VAL_W = 17;
  localparam logic [16:0] VAL_FULL = 17'h1869F;
  localparam logic [16:0] CEIL_RESET = 17'h1869F;
  localparam int DIGITS = 5;
  localparam int RSP_LEN = 9;
  // Persistent settings slots
  localparam logic [1:0] SLOT_CEIL = 2'h0;
  localparam logic [1:0] SLOT_ADDR = 2'h1;
  localparam logic [1:0] SLOT_AMIN = 2'h2;
  localparam logic [1:0] SLOT_AMAX = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hfcl_byte_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR_HI, ST_ADDR_LO, ST_CMD, ST_DIGIT, ST_SEND
  } hfcl_state_e;
endpackage

// [hfcl_store.sv]
`timescale 1ns/1ns
`default_nettype none
// Small settings store; read data is registered
module hfcl_store (
  input wire logic i_clock,
  input wire logic i_enable,
  input wire logic i_we,
  input wire logic [1:0] i_waddr,
  input wire logic [16:0] i_wdata,
  input wire logic [1:0] i_raddr,
  output logic [16:0] o_rdata
);
  logic [16:0] mem [4];

  // No reset: contents stand for non-volatile cells
  always_ff @(posedge i_clock) begin
    if (i_enable) begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

// [hfcl_port.sv]
`timescale 1ns/1ns
`default_nettype none
module hfcl_port (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire hfcl_pkg::hfcl_byte_s i_rx,
  input wire logic i_tx_ready,
  input wire logic i_panel_addr_we,
  input wire logic [4:0] i_panel_addr,
  input wire logic i_running,
  input wire logic [16:0] i_load_current,
  input wire logic [16:0] i_current_demand,
  input wire logic i_amp_we,
  input wire logic [16:0] i_amp_min,
  input wire logic [16:0] i_amp_max,
  input wire logic [16:0] i_amp_rel,
  input wire logic i_restore,
  output hfcl_pkg::hfcl_byte_s o_tx,
  output logic [4:0] o_node_addr,
  output logic [16:0] o_ceiling,
  output logic [16:0] o_peak_current,
  output logic [16:0] o_current_cmd,
  output logic o_limit_active,
  output logic [16:0] o_amp_out
);
  hfcl_pkg::hfcl_state_e state;
  logic [4:0] node_addr;
  logic [16:0] ceiling;
  logic [16:0] amin;
  logic [16:0] amax;
  logic [16:0] peak;
  logic [16:0] acc;
  logic [4:0] rx_addr;
  logic [2:0] digit_cnt;
  logic [3:0] tx_idx;
  logic [16:0] tx_val;
  logic [1:0] restore_step;
  logic restoring;
  logic load_pend;
  logic [1:0] load_slot;
  logic amax_pend;
  logic [16:0] st_rdata;

  // Decimal helpers
  function automatic logic is_digit(input logic [7:0] c);
    return c >= hfcl_pkg::CH_ZERO && c <= 8'h39;
  endfunction
  function automatic logic [3:0] dval(input logic [7:0] c);
    logic [7:0] d;
    d = c - hfcl_pkg::CH_ZERO;
    return d[3:0];
  endfunction

  wire logic rx_v = i_rx.valid;
  wire logic [7:0] rx_d = i_rx.data;
  wire logic [4:0] addr_step = 5'((rx_addr * 5'd10) + 5'(dval(rx_d)));
  wire logic [16:0] acc_step = 17'((acc * 17'd10) + 17'(dval(rx_d)));
  wire logic addr_ok = rx_addr == node_addr;
  wire logic panel_ok = i_panel_addr >= hfcl_pkg::ADDR_MIN
                      && i_panel_addr <= hfcl_pkg::ADDR_MAX;
  wire logic set_frame = rx_v && state == hfcl_pkg::ST_DIGIT
                       && rx_d == hfcl_pkg::CH_CR && digit_cnt == 3'(hfcl_pkg::DIGITS);
  wire logic query_frame = rx_v && state == hfcl_pkg::ST_DIGIT
                         && rx_d == hfcl_pkg::CH_CR && digit_cnt == 3'd0;

  // Limit: full scale means no limiting
  wire logic limit_on = i_running && ceiling != hfcl_pkg::VAL_FULL;
  wire logic clip = limit_on && i_current_demand > ceiling;
  wire logic [16:0] next_cmd = clip ? ceiling : i_current_demand;

  // Amplitude window mapping, rel/FULL across min..max
  wire logic [16:0] span = (amax > amin) ? 17'(amax - amin) : 17'h00000;
  wire logic [33:0] prod = 34'(span) * 34'(i_amp_rel);
  wire logic [16:0] next_amp = 17'(amin + 17'(prod / 34'(hfcl_pkg::VAL_FULL)));

  // Reply digit selection
  function automatic logic [7:0] digit_at(input logic [16:0] v, input logic [3:0] pos);
    logic [16:0] q;
    q = v;
    for (int k = 0; k < 4; k++) begin
      if (k < 4 - (int'(pos) - 4)) begin
        q = q / 17'd10;
      end
    end
    return 8'(q % 17'd10) + hfcl_pkg::CH_ZERO;
  endfunction
  logic [7:0] tx_char;
  always_comb begin
    unique case (tx_idx)
      4'h0: tx_char = hfcl_pkg::CH_RSP;
      4'h1: tx_char = hfcl_pkg::CH_ZERO;
      4'h2: tx_char = hfcl_pkg::CH_ZERO + 8'(hfcl_pkg::ADDR_HOST);
      4'h3: tx_char = hfcl_pkg::CH_CMD;
      4'h9: tx_char = hfcl_pkg::CH_CR;
      default: tx_char = digit_at(tx_val, tx_idx);
    endcase
  end

  // Persistent store: restore walks slots after i_restore; amax follows amin a cycle later
  wire logic st_we = (set_frame && addr_ok) || (i_panel_addr_we && panel_ok) || i_amp_we
                   || amax_pend;
  wire logic [1:0] st_waddr = (set_frame && addr_ok) ? hfcl_pkg::SLOT_CEIL :
                              (i_panel_addr_we && panel_ok) ? hfcl_pkg::SLOT_ADDR :
                              i_amp_we ? hfcl_pkg::SLOT_AMIN : hfcl_pkg::SLOT_AMAX;
  wire logic [16:0] st_wdata = (set_frame && addr_ok) ? acc :
                               (i_panel_addr_we && panel_ok) ? 17'(i_panel_addr) :
                               i_amp_we ? i_amp_min : amax;
  hfcl_store u_store (
    .i_clock(i_clock),
    .i_enable(i_enable),
    .i_we(st_we && !restoring && !load_pend),
    .i_waddr(st_waddr),
    .i_wdata(st_wdata),
    .i_raddr(restore_step),
    .o_rdata(st_rdata)
  );

  // Restore sequencer; one slot read per cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      restoring <= 1'b0;
      restore_step <= 2'h0;
      load_pend <= 1'b0;
      load_slot <= 2'h0;
      amax_pend <= 1'b0;
    end else if (i_enable) begin
      // Read data lags the address by one cycle, so the load trails the walk
      load_pend <= restoring;
      load_slot <= restore_step;
      amax_pend <= i_amp_we;
      if (i_restore && !restoring) begin
        restoring <= 1'b1;
        restore_step <= 2'h0;
      end else if (restoring) begin
        restore_step <= restore_step + 2'h1;
        if (restore_step == hfcl_pkg::SLOT_AMAX) begin
          restoring <= 1'b0;
        end
      end
    end
  end

  // Settings registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      node_addr <= hfcl_pkg::ADDR_DEFAULT;
      ceiling <= hfcl_pkg::CEIL_RESET;
      amin <= 17'h00000;
      amax <= hfcl_pkg::VAL_FULL;
    end else if (i_enable) begin
      if (load_pend) begin
        // Data of the slot read last cycle now out of the store
        unique case (load_slot)
          hfcl_pkg::SLOT_CEIL: ceiling <= st_rdata;
          hfcl_pkg::SLOT_ADDR: node_addr <= st_rdata[4:0];
          hfcl_pkg::SLOT_AMIN: amin <= st_rdata;
          hfcl_pkg::SLOT_AMAX: amax <= st_rdata;
        endcase
      end else begin
        if (set_frame && addr_ok) begin
          ceiling <= acc;
        end
        if (i_panel_addr_we && panel_ok) begin
          node_addr <= i_panel_addr;
        end
        if (i_amp_we) begin
          amin <= i_amp_min;
          amax <= i_amp_max;
        end
      end
    end
  end

  // Frame parser and reply sender
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= hfcl_pkg::ST_IDLE;
      rx_addr <= 5'h00;
      acc <= 17'h00000;
      digit_cnt <= 3'h0;
      tx_idx <= 4'h0;
      tx_val <= 17'h00000;
    end else if (i_enable) begin
      unique case (state)
        hfcl_pkg::ST_IDLE: begin
          if (rx_v && rx_d == hfcl_pkg::CH_REQ) begin
            state <= hfcl_pkg::ST_ADDR_HI;
            rx_addr <= 5'h00;
          end
        end
        hfcl_pkg::ST_ADDR_HI, hfcl_pkg::ST_ADDR_LO: begin
          if (rx_v) begin
            if (is_digit(rx_d)) begin
              rx_addr <= addr_step;
              state <= (state == hfcl_pkg::ST_ADDR_HI) ? hfcl_pkg::ST_ADDR_LO
                                                       : hfcl_pkg::ST_CMD;
            end else begin
              state <= hfcl_pkg::ST_IDLE;
            end
          end
        end
        hfcl_pkg::ST_CMD: begin
          if (rx_v) begin
            acc <= 17'h00000;
            digit_cnt <= 3'h0;
            state <= (rx_d == hfcl_pkg::CH_CMD) ? hfcl_pkg::ST_DIGIT : hfcl_pkg::ST_IDLE;
          end
        end
        hfcl_pkg::ST_DIGIT: begin
          if (rx_v) begin
            if (is_digit(rx_d) && digit_cnt < 3'(hfcl_pkg::DIGITS)) begin
              acc <= acc_step;
              digit_cnt <= digit_cnt + 3'h1;
            end else if (query_frame && addr_ok) begin
              tx_val <= ceiling;
              tx_idx <= 4'h0;
              state <= hfcl_pkg::ST_SEND;
            end else begin
              state <= hfcl_pkg::ST_IDLE;
            end
          end
        end
        hfcl_pkg::ST_SEND: begin
          if (i_tx_ready) begin
            tx_idx <= tx_idx + 4'h1;
            if (tx_idx == 4'(hfcl_pkg::RSP_LEN)) begin
              state <= hfcl_pkg::ST_IDLE;
            end
          end
        end
        default: state <= hfcl_pkg::ST_IDLE;
      endcase
    end
  end

  // Outputs, all registered
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tx <= '0;
      o_node_addr <= hfcl_pkg::ADDR_DEFAULT;
      o_ceiling <= hfcl_pkg::CEIL_RESET;
      peak <= 17'h00000;
      o_current_cmd <= 17'h00000;
      o_limit_active <= 1'b0;
      o_amp_out <= 17'h00000;
    end else if (i_enable) begin
      o_tx.valid <= state == hfcl_pkg::ST_SEND && i_tx_ready;
      o_tx.data <= tx_char;
      o_node_addr <= node_addr;
      o_ceiling <= ceiling;
      if (i_running && i_load_current > peak) begin
        peak <= i_load_current;
      end
      o_current_cmd <= next_cmd;
      o_limit_active <= clip;
      o_amp_out <= next_amp;
    end
  end
  assign o_peak_current = peak;
endmodule
`default_nettype wire

// [hfcl_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module hfcl_monitor (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_panel_addr_we,
  input wire logic [4:0] i_panel_addr,
  input wire logic i_restore,
  input wire logic i_running,
  input wire logic [16:0] i_load_current,
  input wire logic [16:0] i_current_demand,
  input wire hfcl_pkg::hfcl_byte_s o_tx,
  input wire logic [4:0] o_node_addr,
  input wire logic [16:0] o_ceiling,
  input wire logic [16:0] o_peak_current,
  input wire logic [16:0] o_current_cmd
);
  logic [3:0] pos;
  logic ok_addr;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Byte position inside a reply, cleared by its CR
  always_ff @(posedge i_clock) begin
    if (i_rst || (o_tx.valid && o_tx.data == hfcl_pkg::CH_CR)) begin
      pos <= 4'h0;
    end else if (o_tx.valid) begin
      pos <= pos + 4'h1;
    end
  end
  assign ok_addr = i_panel_addr >= hfcl_pkg::ADDR_MIN && i_panel_addr <= hfcl_pkg::ADDR_MAX;
  sequence s_lead; o_tx.valid && pos == 4'h0; endsequence
  sequence s_tail; o_tx.valid && o_tx.data == hfcl_pkg::CH_CR; endsequence
  // Command and ceiling outputs both lag the same internal ceiling by one cycle
  a_cmd_clipped: assert property (!$past(i_rst) && $past(i_running)
    && o_ceiling != hfcl_pkg::VAL_FULL |-> o_current_cmd <= o_ceiling)
    else $error("command above ceiling");
  a_full_unlimited: assert property (!$past(i_rst) && $past(i_running)
    && o_ceiling == hfcl_pkg::VAL_FULL |-> o_current_cmd == $past(i_current_demand))
    else $error("full ceiling still clips");
  a_peak_covers: assert property (!$past(i_rst) && $past(i_running)
    |-> o_peak_current >= $past(i_load_current)) else $error("peak below load");
  a_node_legal: assert property (o_node_addr == hfcl_pkg::ADDR_DEFAULT ||
    (o_node_addr >= hfcl_pkg::ADDR_MIN && o_node_addr <= hfcl_pkg::ADDR_MAX))
    else $error("node address out of range");
  a_panel_refused: assert property (!$past(i_rst) && $past(i_panel_addr_we && !i_restore && !ok_addr)
    |-> ##1 $stable(o_node_addr)) else $error("illegal address taken");
  a_panel_taken: assert property (!$past(i_rst) && $past(i_panel_addr_we && !i_restore && ok_addr)
    |-> ##1 o_node_addr == $past(i_panel_addr, 2)) else $error("panel address lost");
  a_reply_lead: assert property (s_lead |-> o_tx.data == hfcl_pkg::CH_RSP)
    else $error("reply lead byte wrong");
  a_reply_bounded: assert property (s_lead |-> ##[1:1000] s_tail)
    else $error("reply never closed");
endmodule
bind hfcl_port hfcl_monitor mon (.i_clock(i_clock), .i_rst(i_rst), .i_panel_addr_we(i_panel_addr_we),
  .i_panel_addr(i_panel_addr), .i_restore(i_restore), .i_running(i_running),
  .i_load_current(i_load_current), .i_current_demand(i_current_demand), .o_tx(o_tx),
  .o_node_addr(o_node_addr), .o_ceiling(o_ceiling), .o_peak_current(o_peak_current),
  .o_current_cmd(o_current_cmd));
`default_nettype wire

// [hfcl_host.sv]
`timescale 1ns/1ns
`default_nettype none
module hfcl_host (
  input wire logic i_clock,
  input wire hfcl_pkg::hfcl_byte_s i_tx,
  output hfcl_pkg::hfcl_byte_s o_rx,
  output logic o_ready
);
  logic slow = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [7:0] got[$];
  initial o_rx = '{valid: 1'b0, data: 8'h00};
  initial o_ready = 1'b1;
  // Slow mode opens the sink one cycle in four
  always @(posedge i_clock) begin
    phase <= phase + 2'h1;
    o_ready <= !slow || phase == 2'h3;
    if (i_tx.valid) begin
      got.push_back(i_tx.data);
    end
  end
  // Bytes back to back; idle data inverts so no stale byte lingers
  task automatic send(input string s);
    for (int k = 0; k < s.len(); k++) begin
      @(posedge i_clock);
      o_rx <= '{valid: 1'b1, data: s[k]};
    end
    @(posedge i_clock);
    o_rx <= '{valid: 1'b0, data: ~o_rx.data};
  endtask
endmodule
`default_nettype wire

// [hf_current_limit_command_port_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module hf_current_limit_command_port_bench;
  logic clk = 1'b0, rst = 1'b1, pwe = 1'b0, amp_we = 1'b0, restore = 1'b0, running = 1'b0;
  logic rdy, limit;
  logic [4:0] paddr = 5'h00, node;
  logic [16:0] load = 17'h0, demand = 17'h0, amin = 17'h0, amax = 17'h0, arel = 17'h0;
  logic [16:0] ceiling, peak, cmd, amp;
  hfcl_pkg::hfcl_byte_s rx, tx;
  int num_errors = 0, samples_checked = 0, seed = 96, ceil_m = 99999, peak_m = 0;
  string bad[6] = '{"%07A\015", "%06B\015", "%06A12x45\015", "%06A123456\015", "%06A123\015",
    "%02A\015"};
  int pa[5] = '{2, 31, 6, 7, 30};
  int pn[5] = '{6, 6, 6, 7, 30};
  hfcl_port dut (.i_clock(clk), .i_rst(rst), .i_enable(1'b1), .i_rx(rx), .i_tx_ready(rdy),
    .i_panel_addr_we(pwe), .i_panel_addr(paddr), .i_running(running), .i_load_current(load),
    .i_current_demand(demand), .i_amp_we(amp_we), .i_amp_min(amin), .i_amp_max(amax),
    .i_amp_rel(arel), .i_restore(restore), .o_tx(tx), .o_node_addr(node), .o_ceiling(ceiling),
    .o_peak_current(peak), .o_current_cmd(cmd), .o_limit_active(limit), .o_amp_out(amp));
  hfcl_host host (.i_clock(clk), .i_tx(tx), .o_rx(rx), .o_ready(rdy));
  initial forever #5 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Negative value: no reply may come at all
  task automatic reply(input int v);
    string s;
    s = $sformatf("#02A%05d\015", v);
    for (int w = 0; w < 200 && host.got.size() < 10; w++) @(posedge clk);
    check("reply length", 17'(host.got.size()), (v < 0) ? 17'h0 : 17'h0000A);
    for (int k = 0; k < host.got.size() && v >= 0; k++)
      check("reply byte", 17'(host.got[k]), 17'(s[k]));
    host.got.delete();
  endtask
  // Random demand and load; model clips unless ceiling is full scale
  task automatic run(input int n);
    repeat (n) begin
      demand <= 17'($unsigned($random(seed)) % 100000);
      load <= 17'($unsigned($random(seed)) % 100000);
      tick(3);
      peak_m = (load > peak_m) ? load : peak_m;
      check("cmd", cmd, (demand > ceil_m && ceil_m != 99999) ? 17'(ceil_m) : demand);
      check("limit", 17'(limit), 17'(demand > ceil_m && ceil_m != 99999));
      check("peak", peak, 17'(peak_m));
    end
  endtask
  initial begin
    tick(5);
    rst <= 1'b0;
    tick(2);
    check("node", 17'(node), 17'h00006);
    check("ceiling", ceiling, 17'h1869F);
    host.send("%06A\015");
    reply(99999);
    host.send("%06A01234\015");
    ceil_m = 1234;
    host.slow <= 1'b1;
    host.send("%06A\015");
    reply(ceil_m);
    foreach (bad[i]) begin
      host.send(bad[i]);
      reply(-1);
    end
    check("ceiling", ceiling, 17'h004D2);
    $display("test frames done");
    running <= 1'b1;
    run(40);
    host.send("%06A99999\015");
    ceil_m = 99999;
    run(10);
    $display("test limiting done");
    // Panel writes: reserved, too high, old default, both range ends
    foreach (pa[i]) begin
      paddr <= 5'(pa[i]);
      pwe <= 1'b1;
      tick(1);
      pwe <= 1'b0;
      tick(2);
      check("node", 17'(node), 17'(pn[i]));
    end
    host.send("%06A\015");
    reply(-1);
    host.send("%30A00777\015");
    host.send("%30A\015");
    reply(777);
    amin <= 17'h07530;
    amax <= 17'h0EA60;
    amp_we <= 1'b1;
    tick(1);
    amp_we <= 1'b0;
    tick(3);
    check("amp low", amp, 17'h07530);
    arel <= 17'h1869F;
    tick(3);
    check("amp high", amp, 17'h0EA60);
    // Mid-run reset, then settings come back from the store
    rst <= 1'b1;
    tick(5);
    rst <= 1'b0;
    tick(2);
    restore <= 1'b1;
    tick(1);
    restore <= 1'b0;
    // Four slots load one per cycle behind the registered read
    tick(8);
    check("ceiling", ceiling, 17'h00309);
    check("node", 17'(node), 17'h0001E);
    check("amp restored", amp, 17'h0EA60);
    $display("test address and store done");
    tally_and_finish();
  end
  // Whole run needs well under this
  initial begin
    #300000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
